// file: fbmc_uart.sv
// constants shared by the flash boot/mode block, and its async serial engine
// assumes one system clock; serial lines are taken as synchronous to it
package fbmc_pkg;
  // register byte offsets on the bus
  localparam logic [15:0] OFS_PWR_CTRL = 16'h0000;
  localparam logic [15:0] OFS_REG_ENA = 16'h0004;
  localparam logic [15:0] OFS_CTRL_ONE = 16'h0008;
  localparam logic [15:0] OFS_STAT_TWO = 16'h000c;
  localparam logic [15:0] OFS_ERASE_SEL = 16'h0010;
  localparam logic [15:0] OFS_BOOT_STAT = 16'h0014;
  localparam logic [15:0] OFS_RAM_WIN = 16'h4000;
  // field positions
  localparam int PD_DISABLE_BIT = 7;
  localparam int ACCESS_EN_BIT = 7;
  // reset values
  localparam logic [7:0] RST_PWR_CTRL = 8'h00;
  localparam logic [7:0] RST_REG_ENA = 8'h00;
  localparam logic [7:0] RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] RST_ERASE_SEL = 8'h00;
  localparam logic [15:0] RST_BAUD = 16'h0010;
  // download area in on-chip ram
  localparam logic [15:0] RAM_FIRST = 16'hf780;
  localparam logic [15:0] RAM_LAST = 16'hfeef;
  localparam int RAM_DEPTH = int'(RAM_LAST) - int'(RAM_FIRST) + 1;
  // timing: one state is one system clock
  localparam int READY_STATES = 100;
  localparam int READY_CYCLES = READY_STATES;
  localparam int FRAME_LOW_BITS = 9;
  // handshake bytes
  localparam logic [7:0] BYTE_ADJ_DONE = 8'h00;
  localparam logic [7:0] BYTE_HOST_ACK = 8'h55;
  localparam logic [7:0] BYTE_ERASE_OK = 8'haa;
  localparam logic [7:0] BYTE_ERASE_FAIL = 8'hff;
  // operating mode chosen at reset end
  typedef enum logic [1:0] {
    MODE_USER = 2'b00,
    MODE_BOOT = 2'b01,
    MODE_PROGRAMMER = 2'b10,
    MODE_NONE = 2'b11
  } fbmc_mode_type;
  // boot loader sequence
  typedef enum logic [3:0] {
    BS_OFF = 4'b0000,
    BS_SETTLE = 4'b0001,
    BS_ARM = 4'b0010,
    BS_WAIT_LOW = 4'b0011,
    BS_MEASURE = 4'b0100,
    BS_SEND_ADJ = 4'b0101,
    BS_WAIT_ACK = 4'b0110,
    BS_ERASE = 4'b0111,
    BS_LEN_HI = 4'b1000,
    BS_LEN_LO = 4'b1001,
    BS_DATA = 4'b1010,
    BS_SEND_END = 4'b1011,
    BS_JUMP = 4'b1100,
    BS_ABORT = 4'b1101,
    BS_ECHO = 4'b1110
  } fbmc_boot_type;
endpackage

`timescale 1ns/1ps

// 8 data bits, 1 stop bit, no parity, lsb first
module fbmc_uart
  import fbmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bit period in clocks and enables
  input wire logic [15:0] baud,
  input wire logic rx_en,
  input wire logic tx_en,
  // serial lines
  input wire logic rxd,
  output logic txd,
  // byte side
  input wire logic tx_start,
  input wire logic [7:0] tx_byte,
  output logic tx_busy,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_ferr
);
  logic [9:0] tsh_reg;
  logic [3:0] tbits_reg;
  logic [15:0] tcnt_reg;
  logic [3:0] rbits_reg;
  logic [15:0] rcnt_reg;
  logic tick_t;
  logic tick_r;

  // one-cycle bit enables from the two dividers
  assign tick_t = (tcnt_reg <= 16'h0001);
  assign tick_r = (rcnt_reg <= 16'h0001);
  assign tx_busy = (tbits_reg != 4'h0);

  // transmitter: start bit, 8 data, stop bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tsh_reg <= 10'h3ff;
      tbits_reg <= 4'h0;
      tcnt_reg <= 16'h0000;
      txd <= 1'b1;
    end else if (!tx_en) begin
      tbits_reg <= 4'h0;
      txd <= 1'b1;
    end else if (tbits_reg == 4'h0) begin
      if (tx_start) begin
        tsh_reg <= {1'b1, tx_byte, 1'b0};
        tbits_reg <= 4'ha;
        tcnt_reg <= baud;
        txd <= 1'b0;
      end
    end else if (tick_t) begin
      tcnt_reg <= baud;
      tsh_reg <= {1'b1, tsh_reg[9:1]};
      txd <= tsh_reg[1];
      tbits_reg <= tbits_reg - 4'h1;
    end else begin
      tcnt_reg <= tcnt_reg - 16'h0001;
    end
  end

  // receiver: samples mid-bit, flags a bad stop bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rbits_reg <= 4'h0;
      rcnt_reg <= 16'h0000;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rx_ferr <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_en) begin
        rbits_reg <= 4'h0;
      end else if (rbits_reg == 4'h0) begin
        if (!rxd) begin
          rbits_reg <= 4'ha;
          rcnt_reg <= {1'b0, baud[15:1]};
        end
      end else if (tick_r) begin
        rcnt_reg <= baud;
        rbits_reg <= rbits_reg - 4'h1;
        if (rbits_reg == 4'ha && rxd) begin
          rbits_reg <= 4'h0; // glitch, not a start bit
        end else if (rbits_reg == 4'h1) begin
          rx_valid <= 1'b1;
          rx_ferr <= !rxd;
        end else if (rbits_reg != 4'ha) begin
          rx_data <= {rxd, rx_data[7:1]};
        end
      end else begin
        rcnt_reg <= rcnt_reg - 16'h0001;
      end
    end
  end
endmodule

// file: fbmc_top.sv
// flash power/enable registers, reset-end mode select and the boot loader
// assumes an AHB-Lite master, pins synchronous to CLK, an external flash eraser
// Operation
// - subactive powers flash down unless disabled
// - reserved bits of both registers read zero
// - gated registers reachable only with enable set
// - mode chosen from pins at reset end
// - boot receives program over serial into ram
// - whole flash erased before program runs
// - frames are 8 data, 1 stop, no parity
// - time zero-byte low period, set baud
// - measuring starts about 100 states after reset
// - chip sends 00, host answers 55
// - program stored from f780 to feef
// - jump clears rx/tx enables, keeps baud
// - watchdog overflow ends boot mode
// - erase ok sends aa, failure ff aborts
// - length two bytes high first, echoed
//
// Our own choices: register access over AHB-Lite and the register offsets.

`timescale 1ns/1ps

module fbmc_top
  import fbmc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  // mode pins
  input wire logic TEST,
  input wire logic NMI_PIN,
  input wire logic PORT3_BIT6,
  input wire logic PORTB_BIT0,
  input wire logic PORTB_BIT1,
  input wire logic PORTB_BIT2,
  // power and watchdog
  input wire logic SUBACTIVE,
  input wire logic WATCHDOG_OVF,
  output logic FLASH_POWERDOWN,
  // flash eraser handshake
  output logic ERASE_ALL_REQ,
  input wire logic ERASE_DONE,
  input wire logic ERASE_FAIL,
  // serial link and pin state
  input wire logic RXD,
  output logic TXD,
  output logic TXD_PORT_OUT,
  // mode and boot status
  output logic [1:0] MODE,
  output logic BOOT_ACTIVE,
  output logic PROG_START
);
  // bus and register state
  logic pend_reg;
  logic pend_write_reg;
  logic [15:0] pend_addr_reg;
  logic [7:0] pwr_ctrl_reg;
  logic [7:0] reg_ena_reg;
  logic [7:0] ctrl_one_reg;
  logic [7:0] erase_sel_reg;
  // mode and loader state
  logic captured_reg;
  fbmc_mode_type mode_reg;
  fbmc_boot_type bs_reg;
  fbmc_boot_type after_echo_reg;
  logic [19:0] cnt_reg;
  logic [15:0] baud_reg;
  logic rx_enable_bit_reg;
  logic tx_enable_bit_reg;
  logic [15:0] len_reg;
  logic [15:0] wr_ptr_reg;
  logic [7:0] echo_reg;
  logic tx_start_reg;
  logic [7:0] tx_byte_reg;
  logic erase_ok_reg;
  logic [7:0] ram_mem [RAM_DEPTH];
  // serial engine wires
  logic uart_txd;
  logic tx_busy;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_ferr;

  fbmc_uart u_uart (
    .clk(CLK),
    .rst_n(RST_N),
    .baud(baud_reg),
    .rx_en(rx_enable_bit_reg),
    .tx_en(tx_enable_bit_reg),
    .rxd(RXD),
    .txd(uart_txd),
    .tx_start(tx_start_reg),
    .tx_byte(tx_byte_reg),
    .tx_busy(tx_busy),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_ferr(rx_ferr)
  );

  // address decode of the pending data phase
  logic take;
  logic gate_open;
  logic hit_pwr;
  logic hit_ena;
  logic hit_ctl1;
  logic hit_sts2;
  logic hit_ebs;
  logic hit_boot;
  logic hit_ram;
  logic [15:0] ram_idx;
  logic [31:0] rd_word;
  logic [7:0] ram_rd;
  assign take = HSEL && HTRANS[1] && HREADY;
  assign gate_open = reg_ena_reg[ACCESS_EN_BIT];
  assign hit_pwr = (pend_addr_reg == OFS_PWR_CTRL) && gate_open;
  assign hit_ena = (pend_addr_reg == OFS_REG_ENA);
  assign hit_ctl1 = (pend_addr_reg == OFS_CTRL_ONE) && gate_open;
  assign hit_sts2 = (pend_addr_reg == OFS_STAT_TWO) && gate_open;
  assign hit_ebs = (pend_addr_reg == OFS_ERASE_SEL) && gate_open;
  assign hit_boot = (pend_addr_reg == OFS_BOOT_STAT);
  assign ram_idx = {2'b00, pend_addr_reg[15:2]} - {2'b00, OFS_RAM_WIN[15:2]};
  assign hit_ram = (pend_addr_reg[15:14] == OFS_RAM_WIN[15:14])
    && (int'(ram_idx) < RAM_DEPTH);
  assign ram_rd = hit_ram ? ram_mem[ram_idx[10:0]] : 8'h00;

  // read mux; closed gate and reserved bits give zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_pwr) begin
      rd_word = {24'h000000, pwr_ctrl_reg[7], 7'h00};
    end else if (hit_ena) begin
      rd_word = {24'h000000, reg_ena_reg[7], 7'h00};
    end else if (hit_ctl1) begin
      rd_word = {24'h000000, ctrl_one_reg};
    end else if (hit_sts2) begin
      rd_word = {24'h000000, ERASE_FAIL, 7'h00};
    end else if (hit_ebs) begin
      rd_word = {24'h000000, erase_sel_reg};
    end else if (hit_boot) begin
      rd_word = {baud_reg, 4'h0, bs_reg, 2'b00, rx_enable_bit_reg,
        tx_enable_bit_reg, 2'b00, mode_reg};
    end else if (hit_ram) begin
      rd_word = {24'h000000, ram_rd};
    end
  end

  // bus slave: one wait state per transfer, response always okay
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pend_reg <= 1'b0;
      pend_write_reg <= 1'b0;
      pend_addr_reg <= 16'h0000;
      HREADYOUT <= 1'b1;
      HRDATA <= 32'h0000_0000;
      HRESP <= 1'b0;
    end else if (pend_reg) begin
      pend_reg <= 1'b0;
      HREADYOUT <= 1'b1;
      HRDATA <= pend_write_reg ? 32'h0000_0000 : rd_word;
    end else if (take) begin
      pend_reg <= 1'b1;
      pend_write_reg <= HWRITE;
      pend_addr_reg <= {HADDR[15:2], 2'b00};
      HREADYOUT <= 1'b0;
    end
  end

  // software registers; writes through a closed gate are dropped
  logic wr_now;
  assign wr_now = pend_reg && pend_write_reg;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pwr_ctrl_reg <= RST_PWR_CTRL;
      reg_ena_reg <= RST_REG_ENA;
      ctrl_one_reg <= RST_CTRL_ONE;
      erase_sel_reg <= RST_ERASE_SEL;
    end else if (wr_now) begin
      if (hit_pwr) begin
        pwr_ctrl_reg <= {HWDATA[PD_DISABLE_BIT], 7'h00};
      end
      if (hit_ena) begin
        reg_ena_reg <= {HWDATA[ACCESS_EN_BIT], 7'h00};
      end
      if (hit_ctl1) begin
        ctrl_one_reg <= HWDATA[7:0];
      end
      if (hit_ebs) begin
        erase_sel_reg <= HWDATA[7:0];
      end
    end
  end

  // flash power-down follows subactive unless disabled
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FLASH_POWERDOWN <= 1'b0;
    end else begin
      FLASH_POWERDOWN <= SUBACTIVE && !pwr_ctrl_reg[PD_DISABLE_BIT];
    end
  end

  // mode decode from the pins, caught on the first edge after reset
  fbmc_mode_type pin_mode;
  assign pin_mode = (!TEST && NMI_PIN) ? MODE_USER :
    (!TEST && !NMI_PIN && PORT3_BIT6) ? MODE_BOOT :
    (TEST && !PORTB_BIT0 && !PORTB_BIT1 && !PORTB_BIT2) ? MODE_PROGRAMMER :
    MODE_NONE;

  // loader helpers
  logic bit_time_ok;
  logic [19:0] bit_time;
  assign bit_time = cnt_reg / 20'(FRAME_LOW_BITS);
  assign bit_time_ok = (bit_time != 20'h00000) && (bit_time[19:16] == 4'h0);

  // ram fill of the downloaded program
  always_ff @(posedge CLK) begin
    if (bs_reg == BS_DATA && rx_valid && int'(wr_ptr_reg) < RAM_DEPTH) begin
      ram_mem[wr_ptr_reg[10:0]] <= rx_data;
    end
  end

  // boot loader sequence
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      captured_reg <= 1'b0;
      mode_reg <= MODE_NONE;
      bs_reg <= BS_OFF;
      after_echo_reg <= BS_OFF;
      cnt_reg <= 20'h00000;
      baud_reg <= RST_BAUD;
      rx_enable_bit_reg <= 1'b0;
      tx_enable_bit_reg <= 1'b0;
      len_reg <= 16'h0000;
      wr_ptr_reg <= 16'h0000;
      echo_reg <= 8'h00;
      tx_start_reg <= 1'b0;
      tx_byte_reg <= 8'h00;
      erase_ok_reg <= 1'b0;
      ERASE_ALL_REQ <= 1'b0;
      PROG_START <= 1'b0;
      TXD_PORT_OUT <= 1'b0;
    end else begin
      tx_start_reg <= 1'b0;
      if (!captured_reg) begin
        captured_reg <= 1'b1;
        mode_reg <= pin_mode;
        cnt_reg <= 20'h00000;
        if (pin_mode == MODE_BOOT) begin
          bs_reg <= BS_SETTLE;
        end
      end else if (WATCHDOG_OVF && mode_reg == MODE_BOOT) begin
        mode_reg <= MODE_USER;
        bs_reg <= BS_OFF;
        rx_enable_bit_reg <= 1'b0;
        tx_enable_bit_reg <= 1'b0;
        ERASE_ALL_REQ <= 1'b0;
      end else begin
        case (bs_reg)
          BS_SETTLE: begin
            cnt_reg <= cnt_reg + 20'h00001;
            if (cnt_reg == 20'(READY_CYCLES - 1)) begin
              bs_reg <= BS_ARM;
            end
          end
          BS_ARM: begin
            if (RXD) begin
              bs_reg <= BS_WAIT_LOW;
            end
          end
          BS_WAIT_LOW: begin
            cnt_reg <= 20'h00001;
            if (!RXD) begin
              bs_reg <= BS_MEASURE;
            end
          end
          BS_MEASURE: begin
            if (!RXD) begin
              cnt_reg <= cnt_reg + 20'h00001;
            end else if (bit_time_ok) begin
              baud_reg <= bit_time[15:0];
              rx_enable_bit_reg <= 1'b1;
              tx_enable_bit_reg <= 1'b1;
              bs_reg <= BS_SEND_ADJ;
            end else begin
              bs_reg <= BS_WAIT_LOW;
            end
          end
          BS_SEND_ADJ: begin
            if (!tx_busy) begin
              tx_byte_reg <= BYTE_ADJ_DONE;
              tx_start_reg <= 1'b1;
              bs_reg <= BS_WAIT_ACK;
            end
          end
          BS_WAIT_ACK: begin
            if (rx_valid && !rx_ferr && rx_data == BYTE_HOST_ACK) begin
              ERASE_ALL_REQ <= 1'b1;
              bs_reg <= BS_ERASE;
            end
          end
          BS_ERASE: begin
            if ((ERASE_DONE || ERASE_FAIL) && !tx_busy && !tx_start_reg) begin
              ERASE_ALL_REQ <= 1'b0;
              erase_ok_reg <= !ERASE_FAIL;
              tx_byte_reg <= ERASE_FAIL ? BYTE_ERASE_FAIL : BYTE_ERASE_OK;
              tx_start_reg <= 1'b1;
              bs_reg <= ERASE_FAIL ? BS_ABORT : BS_LEN_HI;
            end
          end
          BS_LEN_HI: begin
            if (rx_valid) begin
              len_reg[15:8] <= rx_data;
              echo_reg <= rx_data;
              after_echo_reg <= BS_LEN_LO;
              bs_reg <= BS_ECHO;
            end
          end
          BS_LEN_LO: begin
            if (rx_valid) begin
              len_reg[7:0] <= rx_data;
              echo_reg <= rx_data;
              wr_ptr_reg <= 16'h0000;
              after_echo_reg <= ({len_reg[15:8], rx_data} == 16'h0000) ?
                BS_SEND_END : BS_DATA;
              bs_reg <= BS_ECHO;
            end
          end
          BS_DATA: begin
            if (rx_valid) begin
              echo_reg <= rx_data;
              wr_ptr_reg <= wr_ptr_reg + 16'h0001;
              after_echo_reg <= (wr_ptr_reg + 16'h0001 == len_reg) ?
                BS_SEND_END : BS_DATA;
              bs_reg <= BS_ECHO;
            end
          end
          BS_ECHO: begin
            if (!tx_busy && !tx_start_reg) begin
              tx_byte_reg <= echo_reg;
              tx_start_reg <= 1'b1;
              bs_reg <= after_echo_reg;
            end
          end
          BS_SEND_END: begin
            if (!tx_busy && !tx_start_reg) begin
              tx_byte_reg <= BYTE_ERASE_OK;
              tx_start_reg <= 1'b1;
              bs_reg <= BS_JUMP;
            end
          end
          BS_JUMP: begin
            if (!tx_busy && !tx_start_reg && erase_ok_reg) begin
              rx_enable_bit_reg <= 1'b0;
              tx_enable_bit_reg <= 1'b0;
              TXD_PORT_OUT <= 1'b1;
              PROG_START <= 1'b1;
              bs_reg <= BS_OFF;
            end
          end
          BS_ABORT: begin
            if (!tx_busy && !tx_start_reg) begin
              rx_enable_bit_reg <= 1'b0;
              tx_enable_bit_reg <= 1'b0;
            end
          end
          default: begin
            bs_reg <= BS_OFF;
          end
        endcase
      end
    end
  end

  // pin and status outputs
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      TXD <= 1'b1;
      MODE <= 2'b11;
      BOOT_ACTIVE <= 1'b0;
    end else begin
      TXD <= uart_txd || TXD_PORT_OUT;
      MODE <= mode_reg;
      BOOT_ACTIVE <= (mode_reg == MODE_BOOT) && (bs_reg != BS_OFF);
    end
  end
endmodule

// file: fbmc_asserts.sv
// port-level assertions for the flash boot/mode block
// assumes mode pins stay steady across each reset release and HREADY loops HREADYOUT
`timescale 1ns/1ps

module fbmc_asserts
  import fbmc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // bus
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // mode pins
  input wire logic TEST,
  input wire logic NMI_PIN,
  input wire logic PORT3_BIT6,
  input wire logic PORTB_BIT0,
  input wire logic PORTB_BIT1,
  input wire logic PORTB_BIT2,
  // power, watchdog, eraser, serial
  input wire logic SUBACTIVE,
  input wire logic WATCHDOG_OVF,
  input wire logic FLASH_POWERDOWN,
  input wire logic ERASE_ALL_REQ,
  input wire logic ERASE_DONE,
  input wire logic ERASE_FAIL,
  input wire logic TXD,
  input wire logic TXD_PORT_OUT,
  // status
  input wire logic [1:0] MODE,
  input wire logic BOOT_ACTIVE,
  input wire logic PROG_START
);
  logic [1:0] age_reg;
  logic erased_reg;
  logic failed_reg;
  logic [1:0] mode_exp;
  logic pb_low;

  // mode expected from the pins as they stand
  assign pb_low = {PORTB_BIT2, PORTB_BIT1, PORTB_BIT0} == 3'h0;
  assign mode_exp = TEST ? (pb_low ? MODE_PROGRAMMER : MODE_NONE) :
                    (NMI_PIN ? MODE_USER : (PORT3_BIT6 ? MODE_BOOT : MODE_NONE));

  // edges since reset and erase outcome seen
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      age_reg <= 2'h0;
      erased_reg <= 1'h0;
      failed_reg <= 1'h0;
    end else begin
      if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
      if (ERASE_ALL_REQ && ERASE_DONE) erased_reg <= 1'h1;
      if (ERASE_ALL_REQ && ERASE_FAIL) failed_reg <= 1'h1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_pd_gate: assert property (!SUBACTIVE |=> !FLASH_POWERDOWN)
    else $error("flash powered down outside subactive");
  a_pd_rise: assert property ($rose(FLASH_POWERDOWN) |-> $past(SUBACTIVE))
    else $error("power-down rose without subactive");
  a_mode_pick: assert property (age_reg == 2'h2 |-> MODE == mode_exp)
    else $error("mode differs from pins");
  a_boot_mode: assert property (BOOT_ACTIVE |-> MODE == MODE_BOOT)
    else $error("loader active outside boot mode");
  a_req_boot: assert property (ERASE_ALL_REQ |-> BOOT_ACTIVE)
    else $error("erase request outside loader");
  a_erase_first: assert property (PROG_START |-> erased_reg)
    else $error("program started before erase");
  a_fail_abort: assert property (failed_reg |-> !PROG_START)
    else $error("program started after failed erase");
  a_start_pins: assert property (PROG_START |-> (TXD && TXD_PORT_OUT) ##1 PROG_START)
    else $error("jump pin state lost");
  a_wdt_end: assert property (WATCHDOG_OVF |-> ##[1:2] !BOOT_ACTIVE)
    else $error("watchdog did not end boot");
  a_user_idle: assert property (MODE == MODE_USER && $past(MODE) == MODE_USER |-> TXD)
    else $error("transmit line not idle in user mode");
  a_one_wait: assert property (HSEL && HTRANS[1] && HREADY |=> !HREADYOUT ##1 (HREADYOUT && !HRESP))
    else $error("bus wait state wrong");
endmodule

bind fbmc_top fbmc_asserts u_chk (.*);

// file: fbmc_host.sv
// host computer model on the boot serial link, 8 data, 1 stop, no parity
// assumes the bench calls its tasks just after a rising clock edge
`timescale 1ns/1ps

module fbmc_host #(
  parameter int BIT_CLKS = 20
) (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  logic got;

  // idle high as a pulled-up line, never inverted
  initial line_out = 1'h1;

  // one frame, start bit, lsb first, one stop bit
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
  endtask

  // mid-bit sampling, bad stop bit gives unknown byte
  task automatic recv(output logic [7:0] b);
    while (line_in !== 1'h0) @(posedge clk);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      b[i] = line_in;
    end
    repeat (BIT_CLKS) @(posedge clk);
    if (line_in !== 1'h1) b = 8'hxx;
  endtask

  // zero bytes keep coming until the chip answers
  task automatic calib(output logic [7:0] b);
    got = 1'h0;
    fork
      begin
        recv(b);
        got = 1'h1;
      end
      while (!got) send(8'h00);
    join
  endtask
endmodule

// file: flash_boot_mode_control_tb.sv
// self-checking bench: registers over the bus, power-down, mode pins, boot loader
// assumes the host model on the serial link and an eraser driven from here
`timescale 1ns/1ps

module flash_boot_mode_control_tb
  import fbmc_pkg::*;
;
  localparam int BIT_CLKS = 20;
  logic clk, rst_n, hsel, hwrite, hrdy, test, nmi, p36, pb0, pb1, pb2, sub, wdt;
  logic edone, efail, rxd, hreadyout, hresp, pdown, ereq, txd, txd_port, boot_act, prog_start;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, mode;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;

  fbmc_top dut (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HREADYOUT(hreadyout),
    .HRDATA(hrdata), .HRESP(hresp), .TEST(test), .NMI_PIN(nmi), .PORT3_BIT6(p36),
    .PORTB_BIT0(pb0), .PORTB_BIT1(pb1), .PORTB_BIT2(pb2), .SUBACTIVE(sub),
    .WATCHDOG_OVF(wdt), .FLASH_POWERDOWN(pdown), .ERASE_ALL_REQ(ereq), .ERASE_DONE(edone),
    .ERASE_FAIL(efail), .RXD(rxd), .TXD(txd), .TXD_PORT_OUT(txd_port), .MODE(mode),
    .BOOT_ACTIVE(boot_act), .PROG_START(prog_start));
  fbmc_host #(.BIT_CLKS(BIT_CLKS)) host (.clk(clk), .line_in(txd), .line_out(rxd));

  // single slave, its ready is the bus ready
  assign hrdy = hreadyout;

  // clock and hang guard
  initial clk = 1'h0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one AHB-Lite single transfer, waits on ready in both phases
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'h1;
    haddr <= {16'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(q, e);
  endtask

  // reset with mode pins set long before release and kept after
  task automatic restart(input logic [5:0] pins);
    @(posedge clk);
    rst_n <= 1'h0;
    {test, nmi, p36, pb0, pb1, pb2} <= pins;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_regs();
    rd(OFS_REG_ENA, 32'(RST_REG_ENA));
    wr(OFS_REG_ENA, 32'hff);
    rd(OFS_REG_ENA, 32'h80);
    rd(OFS_PWR_CTRL, 32'(RST_PWR_CTRL));
    wr(OFS_PWR_CTRL, 32'hff);
    rd(OFS_PWR_CTRL, 32'h80);
    wr(OFS_REG_ENA, 32'h0);
    rd(OFS_PWR_CTRL, 32'h0);
    wr(OFS_PWR_CTRL, 32'h0);
    rd(16'h0040, 32'h0);
    wr(OFS_REG_ENA, 32'h80);
    rd(OFS_PWR_CTRL, 32'h80);
    $display("test regs done");
  endtask

  task automatic t_power();
    wr(OFS_PWR_CTRL, 32'h0);
    sub <= 1'h1;
    repeat (2) @(posedge clk);
    chk(32'(pdown), 32'h1);
    wr(OFS_PWR_CTRL, 32'h80);
    repeat (2) @(posedge clk);
    chk(32'(pdown), 32'h0);
    sub <= 1'h0;
    $display("test power done");
  endtask

  task automatic t_modes();
    logic [7:0] tab [4];
    tab = '{8'h40, 8'h7c, 8'h82, 8'he7};
    for (int i = 0; i < 4; i++) begin
      restart(tab[i][7:2]);
      chk(32'(mode), 32'(tab[i][1:0]));
    end
    $display("test modes done");
  endtask

  // host sends a byte and waits for the chip to send it back
  task automatic echo(input logic [7:0] v);
    logic [7:0] r;
    fork
      host.send(v);
      host.recv(r);
    join
    chk(32'(r), 32'(v));
  endtask

  task automatic t_boot(input logic fail);
    logic [7:0] b;
    logic [31:0] q;
    restart(6'h08);
    chk(32'(mode), 32'(MODE_BOOT));
    host.calib(b);
    chk(32'(b), 32'(BYTE_ADJ_DONE));
    if (b !== BYTE_ADJ_DONE) restart(6'h08);
    bus(1'h0, OFS_BOOT_STAT, 32'h0, q);
    chk(32'(q[31:16]), BIT_CLKS);
    host.send(BYTE_HOST_ACK);
    for (int i = 0; i < 400 && ereq !== 1'h1; i++) @(posedge clk);
    chk(32'(ereq), 32'h1);
    efail <= fail;
    edone <= !fail;
    host.recv(b);
    chk(32'(b), fail ? 32'(BYTE_ERASE_FAIL) : 32'(BYTE_ERASE_OK));
    edone <= 1'h0;
    efail <= 1'h0;
    if (!fail) begin
      echo(8'h00);
      echo(8'h03);
      for (int i = 0; i < 3; i++) echo(8'h5a ^ 8'(i));
      host.recv(b);
      chk(32'(b), 32'(BYTE_ERASE_OK));
      for (int i = 0; i < 400 && prog_start !== 1'h1; i++) @(posedge clk);
      chk(32'({prog_start, txd, txd_port}), 32'h7);
      bus(1'h0, OFS_BOOT_STAT, 32'h0, q);
      chk(32'({q[31:16], q[5:4]}), 32'(BIT_CLKS) << 2);
      for (int i = 0; i < 3; i++) rd(OFS_RAM_WIN + 16'(4 * i), 32'(8'h5a ^ 8'(i)));
    end else begin
      repeat (300) @(posedge clk);
      chk(32'(prog_start), 32'h0);
    end
    $display("test boot done");
  endtask

  task automatic t_wdt();
    restart(6'h08);
    repeat (5) @(posedge clk);
    chk(32'(boot_act), 32'h1);
    wdt <= 1'h1;
    @(posedge clk);
    wdt <= 1'h0;
    repeat (3) @(posedge clk);
    chk(32'({boot_act, mode}), 32'(MODE_USER));
    $display("test watchdog done");
  endtask

  // main sequence
  initial begin
    {rst_n, hsel, hwrite, sub, wdt, edone, efail} = 7'h0;
    {test, nmi, p36, pb0, pb1, pb2} = 6'h10;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    restart(6'h10);
    t_regs();
    t_power();
    t_modes();
    t_boot(1'h0);
    t_boot(1'h1);
    t_wdt();
    final_report();
  end
endmodule
